/* rtl/rx_channel_gain_squelch_control.sv */
`timescale 1ns/10ps
// How it works
// RULE1 - Receive chain powered only while receiver-on bit is 1.
// RULE2 - Both channels, manual off: framing channel chosen automatically, pick bit ignored.
// RULE3 - With both channels active, manual bit selects automatic or manual choice.
// RULE4 - Pick bit 0 routes AM/I, 1 routes PM/Q when manual or single.
// RULE5 - Configuration 2 bit selects peak detector or mixer demodulator.
// RULE6 - First stage gain: six 2.5 dB cuts, boost, set only by configuration 3.
// RULE7 - Configuration 3 resets to minimum first-stage gain.
// RULE8 - Three low-pass bits select second-stage cut-off; other codes unused.
// RULE9 - Shared zero bits set first and third stage zeros together.
// RULE10 - Second/third stage gain cut in six 3 dB steps, loops or manual.
// RULE11 - Reset-gain command reinitialises loops and loads manual setting.
// RULE12 - Digitizer window has five settings in 3 dB steps.
// RULE13 - Eleven loop settings: four window steps then six gain cuts.
// RULE14 - Loops start from initial setting in configuration 4.
// RULE15 - Gain-reduction state register reports the loop state.
// RULE16 - Dynamic squelch begins 18.88 us after end of transmission.
// RULE17 - Squelch stops when mask-receive timer reaches squelch timer value.
// RULE18 - Ratio bit selects squelch ratio 1 or 6.
// RULE19 - Ratio 1: over two transitions per 50 us adds a step.
// RULE20 - Ratio 6 uses the comparator with six-times window.
// RULE21 - Loop state latched into state register on receive-active falling edge.
// RULE22 - Gain control runs while receive-active high, reset when low; code only gates AGC steps with it, and does not reset loop state when low.
// RULE23 - Squelch window timed by counting 13.56 MHz reference cycles.
// RULE24 - Loop index saturates at last setting, never wraps.
module rx_channel_gain_squelch_control (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_strobe_i,
	input wire logic [2:0] wr_index_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [2:0] rd_index_i,
	output logic [7:0] rd_data_o,
	input wire logic reset_gain_cmd_i,
	input wire logic tx_end_i,
	input wire logic rx_on_i,
	input wire logic agc_step_i,
	input wire logic [7:0] mask_receive_timer_i,
	input wire logic ref_clk_i,
	input wire logic digitizer_main_i,
	input wire logic digitizer_wide_i,
	output logic rx_power_on_o,
	output logic auto_channel_o,
	output logic decode_channel_pick_o,
	output logic demod_mixer_sel_o,
	output logic [2:0] first_stage_cut_o,
	output logic first_stage_boost_o,
	output logic [2:0] lowpass_code_o,
	output logic lowpass_code_valid_o,
	output logic first_stage_hp_second_order_o,
	output logic third_zero_high_sel_o,
	output logic third_zero_low_sel_o,
	output logic first_zero_lowest_sel_o,
	output logic zero_code_valid_o,
	output logic [2:0] window_step_o,
	output logic [2:0] gain_cut_step_o,
	output logic [3:0] loop_state_o,
	output logic squelch_active_o
);
	import rx_gain_pkg::*;

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] op_ctrl;
	logic [7:0] receiver_filter_config;
	logic [7:0] rx_cfg2;
	logic [7:0] rx_cfg3;
	logic [7:0] rx_cfg4;
	logic [7:0] sq_timer;
	logic [7:0] gain_state;
	logic [7:0] next_op_ctrl;
	logic [7:0] next_receiver_filter_config;
	logic [7:0] next_rx_cfg2;
	logic [7:0] next_rx_cfg3;
	logic [7:0] next_rx_cfg4;
	logic [7:0] next_sq_timer;
	logic [7:0] next_rd_data;
	logic [3:0] init_state;

	always_comb begin
		next_op_ctrl = op_ctrl;
		next_receiver_filter_config = receiver_filter_config;
		next_rx_cfg2 = rx_cfg2;
		next_rx_cfg3 = rx_cfg3;
		next_rx_cfg4 = rx_cfg4;
		next_sq_timer = sq_timer;
		if (wr_strobe_i) begin
			unique case (wr_index_i)
				IDX_OP_CTRL: next_op_ctrl = wr_data_i;
				IDX_FILTER_CFG: next_receiver_filter_config = wr_data_i;
				IDX_RX_CFG2: next_rx_cfg2 = wr_data_i;
				// Only path that changes first-stage gain [RULE6]
				IDX_RX_CFG3: next_rx_cfg3 = wr_data_i;
				IDX_RX_CFG4: next_rx_cfg4 = wr_data_i;
				IDX_SQ_TIMER: next_sq_timer = wr_data_i;
				default: begin
				end
			endcase
		end
		unique case (rd_index_i)
			IDX_OP_CTRL: next_rd_data = op_ctrl;
			IDX_FILTER_CFG: next_rd_data = receiver_filter_config;
			IDX_RX_CFG2: next_rd_data = rx_cfg2;
			IDX_RX_CFG3: next_rd_data = rx_cfg3;
			IDX_RX_CFG4: next_rd_data = rx_cfg4;
			IDX_SQ_TIMER: next_rd_data = sq_timer;
			IDX_GAIN_STATE: next_rd_data = gain_state; // [RULE15]
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_ctrl <= RST_OP_CTRL;
			receiver_filter_config <= RST_FILTER_CFG;
			rx_cfg2 <= RST_RX_CFG2;
			rx_cfg3 <= RST_RX_CFG3; // Minimum first-stage gain [RULE7]
			rx_cfg4 <= RST_RX_CFG4;
			sq_timer <= RST_SQ_TIMER;
			rd_data_o <= 8'h00;
		end else begin
			op_ctrl <= next_op_ctrl;
			receiver_filter_config <= next_receiver_filter_config;
			rx_cfg2 <= next_rx_cfg2;
			rx_cfg3 <= next_rx_cfg3;
			rx_cfg4 <= next_rx_cfg4;
			sq_timer <= next_sq_timer;
			rd_data_o <= next_rd_data;
		end
	end

	// ****************************************
	// Static decode of configuration
	// ****************************************
	logic both_channels;
	logic [3:0] zero_bits;

	assign both_channels = !op_ctrl[OP_SINGLE_CHN];
	assign zero_bits = receiver_filter_config[3:0];
	assign rx_power_on_o = op_ctrl[OP_RX_EN]; // [RULE1]
	// Framing logic picks the channel itself; pick bit ignored [RULE2] [RULE3]
	assign auto_channel_o = both_channels && !op_ctrl[OP_MANUAL];
	assign decode_channel_pick_o = auto_channel_o ? 1'b0 : op_ctrl[OP_CH_PICK]; // [RULE4]
	assign demod_mixer_sel_o = rx_cfg2[C2_MIXER_SEL]; // [RULE5]
	// Cut codes above six clamp to the deepest step [RULE6]
	assign first_stage_cut_o = (rx_cfg3[2:0] == 3'h7) ? 3'h6 : rx_cfg3[2:0];
	assign first_stage_boost_o = rx_cfg3[C3_BOOST];
	assign lowpass_code_o = receiver_filter_config[FC_LP_LSB +: 3];
	// Codes 011, 110 and 111 have no cut-off [RULE8]
	assign lowpass_code_valid_o = !(lowpass_code_o == 3'h3 || lowpass_code_o[2:1] == 2'h3);
	assign first_stage_hp_second_order_o = zero_bits[FC_FIRST_STAGE_HP_SECOND_ORDER]; // [RULE9]
	assign third_zero_high_sel_o = zero_bits[FC_THIRD_ZERO_HIGH_SEL];
	assign third_zero_low_sel_o = zero_bits[FC_H80];
	assign first_zero_lowest_sel_o = zero_bits[FC_FIRST_ZERO_LOWEST_SEL];

	always_comb begin
		// Listed zero combinations only [RULE9]
		unique case (zero_bits)
			4'h0, 4'h4, 4'h2, 4'h1, 4'h3, 4'h5, 4'h8, 4'hc: zero_code_valid_o = 1'b1;
			default: zero_code_valid_o = 1'b0;
		endcase
	end

	// ****************************************
	// Synchronised pins
	// ****************************************
	logic ref_level;
	logic main_level;
	logic wide_level;
	logic ref_prev;
	logic dig_prev;
	logic dig_sel;
	logic ref_tick;
	logic transition;
	logic rx_on_prev;

	pin_sync u_sync_ref (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(ref_clk_i),
		.level_o(ref_level)
	);
	pin_sync u_sync_main (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(digitizer_main_i),
		.level_o(main_level)
	);
	pin_sync u_sync_wide (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(digitizer_wide_i),
		.level_o(wide_level)
	);

	// Ratio 6 watches the six-times comparator [RULE18] [RULE20]
	assign dig_sel = rx_cfg2[C2_RATIO6] ? wide_level : main_level;
	assign ref_tick = ref_level && !ref_prev;
	assign transition = dig_sel != dig_prev;

	// ****************************************
	// Squelch sequencing
	// ****************************************
	squelch_state_t sq_state;
	squelch_state_t next_sq_state;
	logic [11:0] delay_count;
	logic [11:0] next_delay_count;
	logic too_noisy;
	logic quiet;
	logic sq_run;

	assign sq_run = (sq_state == SQ_RUN);
	assign squelch_active_o = sq_run;

	squelch_observer u_observer (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(sq_run),
		.ref_tick_i(ref_tick),
		.transition_i(transition),
		.too_noisy_o(too_noisy),
		.quiet_o(quiet)
	);

	always_comb begin
		next_sq_state = sq_state;
		next_delay_count = delay_count;
		unique case (sq_state)
			SQ_IDLE: begin
				if (tx_end_i && rx_cfg2[C2_SQ_DYN]) begin
					next_sq_state = SQ_WAIT;
					next_delay_count = '0;
				end
			end
			SQ_WAIT: begin
				// Starts 18.88 us after transmit end [RULE16]
				if (delay_count == 12'(SQ_DELAY_CYCLES - 1)) begin
					next_sq_state = SQ_RUN;
				end else begin
					next_delay_count = delay_count + 12'h001;
				end
			end
			SQ_RUN: begin
				// Quiet window or deepest step ends the search [RULE19]
				if (quiet || (too_noisy && loop_state_o == LOOP_MAX)) begin
					next_sq_state = SQ_DONE;
				end
			end
			SQ_DONE: begin
			end
		endcase
		// Mask-receive timer reaching the limit ends squelch [RULE17]
		if (sq_state != SQ_IDLE && mask_receive_timer_i >= sq_timer) begin
			next_sq_state = SQ_IDLE;
		end
		if (!rx_cfg2[C2_SQ_DYN]) begin
			next_sq_state = SQ_IDLE;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sq_state <= SQ_IDLE;
			delay_count <= '0;
			ref_prev <= 1'b0;
			dig_prev <= 1'b0;
			rx_on_prev <= 1'b0;
		end else begin
			sq_state <= next_sq_state;
			delay_count <= next_delay_count;
			ref_prev <= ref_level;
			dig_prev <= dig_sel;
			rx_on_prev <= rx_on_i;
		end
	end

	// ****************************************
	// Shared loop state
	// ****************************************
	logic [3:0] next_loop_state;
	logic [7:0] next_gain_state;
	logic step_req;

	// Out-of-range initial values clamp to the last setting
	assign init_state = (rx_cfg4[3:0] > LOOP_MAX) ? LOOP_MAX : rx_cfg4[3:0]; // [RULE14]
	// AGC steps only act while receive-active is high; squelch steps do not need it [RULE22]
	assign step_req = (sq_run && too_noisy) || (agc_step_i && rx_on_i);

	always_comb begin
		next_loop_state = loop_state_o;
		next_gain_state = gain_state;
		if (reset_gain_cmd_i) begin
			// Reinitialises the loop index, loads manual setting [RULE11] [RULE14]
			next_loop_state = init_state;
		end else if (step_req && loop_state_o != LOOP_MAX) begin
			next_loop_state = loop_state_o + 4'h1; // [RULE24]
		end
		if (rx_on_prev && !rx_on_i) begin
			next_gain_state = {4'h0, loop_state_o}; // [RULE21]
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			loop_state_o <= 4'h0;
			gain_state <= 8'h00;
		end else begin
			loop_state_o <= next_loop_state;
			gain_state <= next_gain_state;
		end
	end

	// Window widens first, then gain drops [RULE13] [RULE12] [RULE10]
	assign window_step_o = (loop_state_o > WINDOW_STEPS) ? 3'h4 : loop_state_o[2:0];
	assign gain_cut_step_o = (loop_state_o > WINDOW_STEPS) ?
		3'(loop_state_o - WINDOW_STEPS) : 3'h0;
endmodule : rx_channel_gain_squelch_control

/* rtl/rx_gain_pkg.sv */
package rx_gain_pkg;
	// ****************************************
	// Register indexes on the write/read port
	// ****************************************
	localparam logic [2:0] IDX_OP_CTRL = 3'h0;
	localparam logic [2:0] IDX_FILTER_CFG = 3'h1;
	localparam logic [2:0] IDX_RX_CFG2 = 3'h2;
	localparam logic [2:0] IDX_RX_CFG3 = 3'h3;
	localparam logic [2:0] IDX_RX_CFG4 = 3'h4;
	localparam logic [2:0] IDX_SQ_TIMER = 3'h5;
	localparam logic [2:0] IDX_GAIN_STATE = 3'h6;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int OP_RX_EN = 6;
	localparam int OP_SINGLE_CHN = 5;
	localparam int OP_MANUAL = 4;
	localparam int OP_CH_PICK = 3;
	localparam int FC_LP_LSB = 3;
	localparam int FC_FIRST_STAGE_HP_SECOND_ORDER = 3;
	localparam int FC_THIRD_ZERO_HIGH_SEL = 2;
	localparam int FC_H80 = 1;
	localparam int FC_FIRST_ZERO_LOWEST_SEL = 0;
	localparam int C2_MIXER_SEL = 0;
	localparam int C2_RATIO6 = 1;
	localparam int C2_SQ_DYN = 2;
	localparam int C3_BOOST = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_OP_CTRL = 8'h00;
	localparam logic [7:0] RST_FILTER_CFG = 8'h00;
	localparam logic [7:0] RST_RX_CFG2 = 8'h00;
	localparam logic [7:0] RST_RX_CFG3 = 8'h06;
	localparam logic [7:0] RST_RX_CFG4 = 8'h00;
	localparam logic [7:0] RST_SQ_TIMER = 8'h00;

	// ****************************************
	// Loop state and timing
	// ****************************************
	localparam logic [3:0] LOOP_MAX = 4'ha;
	localparam logic [3:0] WINDOW_STEPS = 4'h4;
	localparam logic [9:0] SQ_TRANS_LIMIT = 10'h002;
	localparam int SYS_CLK_MHZ = 125;
	localparam int SQ_DELAY_NS = 18880;
	localparam int SQ_DELAY_CYCLES = (SQ_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int REF_CLK_KHZ = 13560;
	localparam int SQ_WINDOW_NS = 50000;
	localparam int SQ_WINDOW_REF = (SQ_WINDOW_NS * REF_CLK_KHZ) / 1000000;

	typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_RUN, SQ_DONE} squelch_state_t;
endpackage : rx_gain_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	always_comb begin
		next_level = level_o;
		// Change counts only once second and third stage agree
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			level_o <= next_level;
		end
	end
endmodule : pin_sync

/* rtl/squelch_observer.sv */
`timescale 1ns/10ps
module squelch_observer (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic ref_tick_i,
	input wire logic transition_i,
	output logic too_noisy_o,
	output logic quiet_o
);
	import rx_gain_pkg::*;

	logic [9:0] ref_count;
	logic [9:0] trans_count;
	logic [9:0] next_ref_count;
	logic [9:0] next_trans_count;
	logic next_too_noisy;
	logic next_quiet;
	logic window_end;

	// Window timed in reference clock cycles [RULE23]
	assign window_end = run_i && ref_tick_i && (ref_count == 10'(SQ_WINDOW_REF - 1));

	always_comb begin
		next_ref_count = ref_count;
		next_trans_count = trans_count;
		next_too_noisy = 1'b0;
		next_quiet = 1'b0;
		if (!run_i) begin
			next_ref_count = '0;
			next_trans_count = '0;
		end else begin
			if (transition_i && trans_count != 10'h3ff) begin
				next_trans_count = trans_count + 10'h001;
			end
			if (window_end) begin
				// More than two transitions asks for one more step [RULE19]
				next_too_noisy = (trans_count > SQ_TRANS_LIMIT);
				next_quiet = (trans_count <= SQ_TRANS_LIMIT);
				next_ref_count = '0;
				next_trans_count = '0;
			end else if (ref_tick_i) begin
				next_ref_count = ref_count + 10'h001;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_count <= '0;
			trans_count <= '0;
			too_noisy_o <= 1'b0;
			quiet_o <= 1'b0;
		end else begin
			ref_count <= next_ref_count;
			trans_count <= next_trans_count;
			too_noisy_o <= next_too_noisy;
			quiet_o <= next_quiet;
		end
	end
endmodule : squelch_observer

/* verification/rx_gain_asserts.sv */
`timescale 1ns/10ps
module rx_gain_asserts
	import rx_gain_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_strobe_i,
	input wire logic [2:0] wr_index_i,
	input wire logic [7:0] wr_data_i,
	input wire logic reset_gain_cmd_i,
	input wire logic rx_on_i,
	input wire logic agc_step_i,
	input wire logic [7:0] mask_receive_timer_i,
	input wire logic rx_power_on_o,
	input wire logic auto_channel_o,
	input wire logic decode_channel_pick_o,
	input wire logic [2:0] first_stage_cut_o,
	input wire logic [2:0] lowpass_code_o,
	input wire logic lowpass_code_valid_o,
	input wire logic [2:0] window_step_o,
	input wire logic [2:0] gain_cut_step_o,
	input wire logic [3:0] loop_state_o,
	input wire logic squelch_active_o
);
	// ****************************************
	// Shadows of the loop start and squelch stop values
	// ****************************************
	logic [3:0] init_sh;
	logic [3:0] next_init_sh;
	logic [7:0] sq_sh;
	logic [7:0] next_sq_sh;
	logic [3:0] init_lim;
	assign init_lim = (init_sh > LOOP_MAX) ? LOOP_MAX : init_sh;
	always_comb begin
		next_init_sh = init_sh;
		next_sq_sh = sq_sh;
		if (wr_strobe_i && wr_index_i == IDX_RX_CFG4) begin
			next_init_sh = wr_data_i[3:0];
		end
		if (wr_strobe_i && wr_index_i == IDX_SQ_TIMER) begin
			next_sq_sh = wr_data_i;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_sh <= RST_RX_CFG4[3:0];
			sq_sh <= RST_SQ_TIMER;
		end else begin
			init_sh <= next_init_sh;
			sq_sh <= next_sq_sh;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_power_follows_bit: assert property (wr_strobe_i && wr_index_i == IDX_OP_CTRL
		|=> rx_power_on_o == $past(wr_data_i[OP_RX_EN])) else $error("power bit not followed");
	a_auto_pick_zero: assert property (auto_channel_o |-> !decode_channel_pick_o)
		else $error("pick set in automatic mode");
	a_cut_clamped: assert property (first_stage_cut_o <= 3'h6)
		else $error("first stage cut beyond six");
	a_lowpass_valid: assert property (lowpass_code_valid_o ==
		!(lowpass_code_o inside {3'h3, 3'h6, 3'h7})) else $error("lowpass valid wrong");
	a_loop_saturates: assert property (loop_state_o <= LOOP_MAX)
		else $error("loop index beyond last setting");
	a_window_split: assert property ({1'b0, window_step_o} + {1'b0, gain_cut_step_o}
		== loop_state_o) else $error("window and gain split wrong");
	a_reset_loads_init: assert property (reset_gain_cmd_i |=> loop_state_o == $past(init_lim))
		else $error("reset command did not load start value");
	a_step_adds_one: assert property (agc_step_i && rx_on_i && !reset_gain_cmd_i
		&& !squelch_active_o && loop_state_o < LOOP_MAX
		|=> loop_state_o == $past(loop_state_o) + 4'h1) else $error("step not taken");
	a_mask_stops_squelch: assert property (squelch_active_o && mask_receive_timer_i >= sq_sh
		|=> !squelch_active_o) else $error("squelch ran past timer");
	cover property ($rose(squelch_active_o));
	cover property (loop_state_o == LOOP_MAX && agc_step_i && rx_on_i);
	cover property (reset_gain_cmd_i);
endmodule : rx_gain_asserts

bind rx_channel_gain_squelch_control rx_gain_asserts u_chk (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .wr_strobe_i(wr_strobe_i), .wr_index_i(wr_index_i), .wr_data_i(wr_data_i),
	.reset_gain_cmd_i(reset_gain_cmd_i), .rx_on_i(rx_on_i), .agc_step_i(agc_step_i),
	.mask_receive_timer_i(mask_receive_timer_i), .rx_power_on_o(rx_power_on_o),
	.auto_channel_o(auto_channel_o), .decode_channel_pick_o(decode_channel_pick_o),
	.first_stage_cut_o(first_stage_cut_o), .lowpass_code_o(lowpass_code_o),
	.lowpass_code_valid_o(lowpass_code_valid_o), .window_step_o(window_step_o),
	.gain_cut_step_o(gain_cut_step_o), .loop_state_o(loop_state_o),
	.squelch_active_o(squelch_active_o));

/* verification/far_side_model.sv */
`timescale 1ns/10ps
module far_side_model (
	input wire logic noise_main_i,
	input wire logic noise_wide_i,
	output logic ref_clk_o,
	output logic dig_main_o,
	output logic dig_wide_o
);
	// Crystal reference runs free, unrelated to the system clock
	initial begin
		ref_clk_o = 1'b0;
		forever #36.87 ref_clk_o = ~ref_clk_o;
	end
	// Noise toggles far above two transitions per window; quiet holds low
	initial begin
		dig_main_o = 1'b0;
		dig_wide_o = 1'b0;
		forever begin
			#500;
			dig_main_o = noise_main_i & ~dig_main_o;
			dig_wide_o = noise_wide_i & ~dig_wide_o;
		end
	end
endmodule : far_side_model

/* verification/rx_channel_gain_squelch_control_bench.sv */
`timescale 1ns/10ps
module rx_channel_gain_squelch_control_bench;
	import rx_gain_pkg::*;
	typedef struct {int sel; logic [7:0] exp;} note_t;
	note_t q[$];
	int bad_count = 0;
	int total_checks = 0;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_strobe = 1'b0;
	logic [2:0] wr_index = 3'h0;
	logic [7:0] wr_data = 8'h00;
	logic [2:0] rd_index = 3'h0;
	logic gain_cmd = 1'b0;
	logic tx_end = 1'b0;
	logic rx_on = 1'b0;
	logic agc_step = 1'b0;
	logic [7:0] mask_receive_timer = 8'h00;
	logic noise_main = 1'b0;
	logic noise_wide = 1'b0;
	logic ref_clk, dig_main, dig_wide, power, auto_ch, pick, mixer, boost, lp_ok, z_ok, sq_act;
	logic hp2, zh, zl, zlow;
	logic [7:0] rd_data;
	logic [2:0] cut, lp, win, gcut;
	logic [3:0] loop_st;
	far_side_model tag (.noise_main_i(noise_main), .noise_wide_i(noise_wide),
		.ref_clk_o(ref_clk), .dig_main_o(dig_main), .dig_wide_o(dig_wide));
	rx_channel_gain_squelch_control uut (.sys_clk_i(clk), .rst_n_i(rst_n),
		.wr_strobe_i(wr_strobe), .wr_index_i(wr_index), .wr_data_i(wr_data),
		.rd_index_i(rd_index), .rd_data_o(rd_data), .reset_gain_cmd_i(gain_cmd),
		.tx_end_i(tx_end), .rx_on_i(rx_on), .agc_step_i(agc_step), .mask_receive_timer_i(mask_receive_timer),
		.ref_clk_i(ref_clk), .digitizer_main_i(dig_main), .digitizer_wide_i(dig_wide),
		.rx_power_on_o(power), .auto_channel_o(auto_ch), .decode_channel_pick_o(pick),
		.demod_mixer_sel_o(mixer), .first_stage_cut_o(cut), .first_stage_boost_o(boost),
		.lowpass_code_o(lp), .lowpass_code_valid_o(lp_ok), .first_stage_hp_second_order_o(hp2),
		.third_zero_high_sel_o(zh), .third_zero_low_sel_o(zl), .first_zero_lowest_sel_o(zlow),
		.zero_code_valid_o(z_ok), .window_step_o(win), .gain_cut_step_o(gcut),
		.loop_state_o(loop_st), .squelch_active_o(sq_act));
	initial begin
		forever #4 clk = ~clk;
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	function automatic logic [7:0] obs(input int s);
		case (s)
			0: return rd_data;
			1: return {7'h00, power};
			2: return {6'h00, auto_ch, pick};
			3: return {6'h00, lp_ok, z_ok};
			4: return {4'h0, loop_st};
			5: return {7'h00, sq_act};
			6: return {3'h0, boost, cut, mixer};
			7: return {2'h0, win, gcut};
			default: return {1'b0, lp, hp2, zh, zl, zlow};
		endcase
	endfunction : obs
	task automatic note(input int s, input logic [7:0] e);
		q.push_back('{s, e});
	endtask : note
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		@(negedge clk);
		wr_strobe = 1'b1;
		wr_index = i;
		wr_data = d;
		@(negedge clk);
		wr_strobe = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] i, input logic [7:0] e);
		@(negedge clk);
		rd_index = i;
		@(negedge clk);
		note(0, e);
	endtask : rd
	task automatic pulse(input int w);
		@(negedge clk);
		if (w == 0) gain_cmd = 1'b1;
		else if (w == 1) agc_step = 1'b1;
		else tx_end = 1'b1;
		@(negedge clk);
		gain_cmd = 1'b0;
		agc_step = 1'b0;
		tx_end = 1'b0;
	endtask : pulse
	// Squelch only restarts from idle, so the timer is reached first
	task automatic sq_start;
		@(negedge clk);
		mask_receive_timer = 8'h40;
		@(negedge clk);
		mask_receive_timer = 8'h00;
		pulse(2);
	endtask : sq_start
	task automatic final_report;
		$display("Checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	always @(negedge clk) begin
		// Settle past notes pushed on this same edge; outputs move only on rising edges
		#2;
		while (q.size() > 0) begin
			note_t n;
			n = q.pop_front();
			total_checks++;
			if (obs(n.sel) !== n.exp) begin
				bad_count++;
				$display("Error %0t: item %0d got %h want %h", $time, n.sel, obs(n.sel), n.exp);
			end
		end
	end
	initial begin
		#600000;
		bad_count++;
		$display("Error %0t: watchdog expired", $time);
		final_report();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin : main
		logic [7:0] r;
		logic [3:0] e;
		r = 8'h3b;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		note(6, 8'h0c);
		rd(IDX_GAIN_STATE, 8'h00);
		rd(3'h7, 8'h00);
		for (int k = 0; k < 8; k++) begin
			r = lfsr(r);
			wr(IDX_OP_CTRL, {r[7:6], k[2:0], r[2:0]});
			note(1, {7'h00, r[6]});
			note(2, {6'h00, k[2:1] == 2'b00, k[2:1] != 2'b00 && k[0]});
		end
		for (int k = 0; k < 64; k++) begin
			r = lfsr(r);
			wr(IDX_FILTER_CFG, {r[7:6], k[5:0]});
			note(3, {6'h00, !(k[5:3] inside {3, 6, 7}), k[3:0] inside {0, 1, 2, 3, 4, 5, 8, 12}});
			note(8, {1'b0, k[5:3], k[3:0]});
		end
		for (int k = 0; k < 16; k++) begin
			wr(IDX_RX_CFG3, {4'h0, k[3:0]});
			note(6, {3'h0, k[3], k[2:0] == 3'h7 ? 3'h6 : k[2:0], 1'b0});
		end
		wr(IDX_RX_CFG2, 8'h01);
		note(6, 8'h1d);
		wr(IDX_RX_CFG4, 8'h0f);
		pulse(0);
		note(4, 8'h0a);
		wr(IDX_RX_CFG4, 8'h03);
		pulse(0);
		note(7, {2'h0, 3'h3, 3'h0});
		rx_on = 1'b1;
		for (int k = 4; k < 12; k++) begin
			pulse(1);
			e = k > 10 ? 4'ha : k[3:0];
			note(4, {4'h0, e});
			note(7, {2'h0, e > 4 ? 3'h4 : e[2:0], e > 4 ? e[2:0] - 3'h4 : 3'h0});
		end
		rx_on = 1'b0;
		repeat (3) @(negedge clk);
		rd(IDX_GAIN_STATE, 8'h0a);
		pulse(0);
		pulse(1);
		note(4, 8'h03);
		rd(IDX_GAIN_STATE, 8'h0a);
		wr(IDX_SQ_TIMER, 8'h40);
		wr(IDX_RX_CFG4, 8'h08);
		pulse(0);
		noise_wide = 1'b1;
		wr(IDX_RX_CFG2, 8'h04);
		sq_start();
		repeat (SQ_DELAY_CYCLES - 3) @(negedge clk);
		note(5, 8'h00);
		repeat (4) @(negedge clk);
		note(5, 8'h01);
		repeat (7000) @(negedge clk);
		note(4, 8'h08);
		note(5, 8'h00);
		wr(IDX_RX_CFG2, 8'h06);
		sq_start();
		repeat (2400 + 4 * 6300) @(negedge clk);
		note(4, 8'h0a);
		note(5, 8'h00);
		wr(IDX_RX_CFG4, 8'h00);
		pulse(0);
		sq_start();
		repeat (2400) @(negedge clk);
		note(5, 8'h01);
		mask_receive_timer = 8'h40;
		repeat (3) @(negedge clk);
		note(5, 8'h00);
		mask_receive_timer = 8'h00;
		repeat (3) @(negedge clk);
		final_report();
	end
endmodule : rx_channel_gain_squelch_control_bench
